// ===== rtl/hrps_pkg.sv
// package for the hardware reset and pin state block
package hrps_pkg;

  // least reset hold, in main-clock cycles
  localparam int unsigned RST_MIN_CYCLES = 20;
  localparam logic [4:0]  HOLD_CNT_RST   = 5'h00;
  // reset vector entry address (20-bit space)
  localparam logic [19:0] RESET_VECTOR_ADDR = 20'hFFFFC;
  localparam logic [19:0] FETCH_ADDR_RST    = 20'h00000;

  typedef enum logic [1:0] {
    HRPS_IN_RESET,
    HRPS_VECTOR,
    HRPS_RUN
  } hrps_state_t;

  // external bus strobes and control pins
  typedef struct packed {
    logic chip_select_zero;
    logic wr_strobe;
    logic rd_strobe;
    logic addr_latch;
    logic bus_release_ack;
    logic upper_byte_enable;
  } hrps_bus_ctl_t;

  // cpu side ram write request
  typedef struct packed {
    logic        we;
    logic [13:0] addr;
    logic [7:0]  data;
  } hrps_ram_wr_t;

endpackage : hrps_pkg

// ===== rtl/hrps_core.sv
// reset sequencer with pin states during reset and guarded ram writes
`timescale 1ns/10ps
module hrps_core
  import hrps_pkg::*;
#(
  parameter int RAM_WORDS = 16384,
  parameter int PORT_W    = 8
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // reset sources, active low pin and software request
  input  wire logic                reset_n_pin,
  input  wire logic                soft_reset,
  input  wire logic                main_clk_stable,
  input  wire logic                processor_mode_pin,
  input  wire logic                bus_16bit,
  // bus grant request from outside
  input  wire logic                bus_grant_req,
  // cpu side
  input  hrps_ram_wr_t             ram_wr,
  input  wire logic [13:0]         ram_rd_addr,
  input  wire logic [19:0]         cpu_addr,
  input  hrps_bus_ctl_t            cpu_bus_ctl,
  // status
  output logic                     core_in_reset,
  output logic                     fetch_valid,
  output logic [19:0]              fetch_addr,
  output logic [7:0]               ram_rd_data,
  // external pins
  output hrps_bus_ctl_t            bus_ctl,
  output logic                     bus_ctl_oe,
  output logic                     bus_clk_out,
  output logic                     bus_clk_oe,
  output logic [19:0]              addr_out,
  output logic                     addr_oe,
  output logic [PORT_W-1:0]        data_lo_oe,
  output logic [PORT_W-1:0]        data_hi_oe,
  output logic [2:0]               pulled_up_port_pins,
  output logic [2:0]               pulled_up_port_pins_oe
);

  hrps_state_t      state_ff, nxt_state;
  logic [4:0]       hold_cnt_ff, nxt_hold_cnt;
  logic             in_reset_ff, nxt_in_reset;
  logic             fetch_valid_ff, nxt_fetch_valid;
  logic [19:0]      fetch_addr_ff, nxt_fetch_addr;
  logic             rst_req;

  // a soft request enters the same path as the pin
  assign rst_req = !reset_n_pin || soft_reset;

  always_comb begin
    nxt_state       = state_ff;
    nxt_hold_cnt    = hold_cnt_ff;
    nxt_in_reset    = in_reset_ff;
    nxt_fetch_valid = 1'b0;
    nxt_fetch_addr  = fetch_addr_ff;
    if (rst_req) begin
      // shorter pulses still reset; only the count is a guide
      nxt_state    = HRPS_IN_RESET;
      nxt_in_reset = 1'b1;
      if (hold_cnt_ff != 5'(RST_MIN_CYCLES))
        nxt_hold_cnt = hold_cnt_ff + 5'h01;
    end else begin
      case (state_ff)
        HRPS_IN_RESET: begin
          // release waits for a stable main clock
          if (main_clk_stable) begin
            nxt_state       = HRPS_VECTOR;
            nxt_in_reset    = 1'b0;
            nxt_hold_cnt    = HOLD_CNT_RST;
          end
        end
        HRPS_VECTOR: begin
          nxt_fetch_valid = 1'b1;
          nxt_fetch_addr  = RESET_VECTOR_ADDR;
          nxt_state       = HRPS_RUN;
        end
        HRPS_RUN: nxt_state = HRPS_RUN;
        default:  nxt_state = HRPS_IN_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff       <= HRPS_IN_RESET;
      hold_cnt_ff    <= HOLD_CNT_RST;
      in_reset_ff    <= 1'b1;
      fetch_valid_ff <= 1'b0;
      fetch_addr_ff  <= FETCH_ADDR_RST;
    end else begin
      state_ff       <= nxt_state;
      hold_cnt_ff    <= nxt_hold_cnt;
      in_reset_ff    <= nxt_in_reset;
      fetch_valid_ff <= nxt_fetch_valid;
      fetch_addr_ff  <= nxt_fetch_addr;
    end
  end

  assign core_in_reset = in_reset_ff;
  assign fetch_valid   = fetch_valid_ff;
  assign fetch_addr    = fetch_addr_ff;

  // ram holds no reset value; contents start undefined
  logic [7:0] ram_mem [RAM_WORDS];
  logic [7:0] ram_rd_ff;
  logic       ram_we_ok;

  // a write racing a reset request is dropped, leaving the old word
  assign ram_we_ok = ram_wr.we && !rst_req && !in_reset_ff;

  always_ff @(posedge core_clk) begin
    if (ram_we_ok)
      ram_mem[ram_wr.addr] <= ram_wr.data;
    ram_rd_ff <= ram_mem[ram_rd_addr];
  end
  assign ram_rd_data = ram_rd_ff;

  // pin states
  hrps_bus_ctl_t   nxt_bus_ctl, bus_ctl_ff;
  logic            nxt_ctl_oe, ctl_oe_ff;
  logic            nxt_bclk_oe, bclk_oe_ff, bclk_ff, nxt_bclk;
  logic [19:0]     nxt_addr, addr_ff;
  logic            nxt_addr_oe, addr_oe_ff;
  logic            nxt_dlo_oe, nxt_dhi_oe, dlo_oe_ff, dhi_oe_ff;
  logic            nxt_pu_oe, pu_oe_ff;
  logic [2:0]      nxt_pu_en, pu_en_ff;
  logic            hold_rst;
  logic            ext_mode;

  assign hold_rst = rst_req || in_reset_ff;
  assign ext_mode = processor_mode_pin;

  always_comb begin
    nxt_bus_ctl = cpu_bus_ctl;
    nxt_ctl_oe  = ext_mode;
    nxt_bclk_oe = ext_mode;
    nxt_addr    = cpu_addr;
    nxt_addr_oe = ext_mode;
    nxt_dlo_oe  = 1'b0;
    nxt_dhi_oe  = 1'b0;
    nxt_pu_oe   = 1'b0;
    nxt_pu_en   = pu_en_ff;
    nxt_bclk    = !bclk_ff;
    if (hold_rst) begin
      if (!ext_mode) begin
        // single-chip: nothing driven
        nxt_ctl_oe  = 1'b0;
        nxt_bclk_oe = 1'b0;
        nxt_addr_oe = 1'b0;
      end else begin
        nxt_bus_ctl.chip_select_zero = 1'b1;
        nxt_bus_ctl.wr_strobe        = 1'b1;
        nxt_bus_ctl.rd_strobe        = 1'b1;
        nxt_bus_ctl.addr_latch       = 1'b0;
        nxt_bus_ctl.bus_release_ack  = bus_grant_req;
        // address and byte enable pass through, undefined to the outside
        nxt_addr_oe = 1'b1;
        nxt_bclk_oe = 1'b1;
      end
      // pulled-up pins and data lanes stay inputs
      nxt_pu_oe = 1'b0;
      nxt_pu_en = 3'h7;
    end else if (ext_mode) begin
      nxt_bus_ctl.bus_release_ack = cpu_bus_ctl.bus_release_ack;
    end
    // upper lane drives only beside the lower one on a 16-bit bus
    nxt_dhi_oe = nxt_dlo_oe && bus_16bit;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_ctl_ff <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      ctl_oe_ff  <= 1'b0;
      bclk_oe_ff <= 1'b0;
      bclk_ff    <= 1'b0;
      addr_ff    <= 20'h00000;
      addr_oe_ff <= 1'b0;
      dlo_oe_ff  <= 1'b0;
      dhi_oe_ff  <= 1'b0;
      pu_oe_ff   <= 1'b0;
      pu_en_ff   <= 3'h7;
    end else begin
      bus_ctl_ff <= nxt_bus_ctl;
      ctl_oe_ff  <= nxt_ctl_oe;
      bclk_oe_ff <= nxt_bclk_oe;
      bclk_ff    <= nxt_bclk;
      addr_ff    <= nxt_addr;
      addr_oe_ff <= nxt_addr_oe;
      dlo_oe_ff  <= nxt_dlo_oe;
      dhi_oe_ff  <= nxt_dhi_oe;
      pu_oe_ff   <= nxt_pu_oe;
      pu_en_ff   <= nxt_pu_en;
    end
  end

  assign bus_ctl                = bus_ctl_ff;
  assign bus_ctl_oe             = ctl_oe_ff;
  assign bus_clk_out            = bclk_ff;
  assign bus_clk_oe             = bclk_oe_ff;
  assign addr_out               = addr_ff;
  assign addr_oe                = addr_oe_ff;
  assign data_lo_oe             = {PORT_W{dlo_oe_ff}};
  assign data_hi_oe             = {PORT_W{dhi_oe_ff}};
  // pull-ups stay on after reset; later control is not this block's
  assign pulled_up_port_pins    = pu_en_ff;
  assign pulled_up_port_pins_oe = {3{pu_oe_ff}};

endmodule : hrps_core

// ===== testbench/hrps_chk.sv
// checker for pin states in reset and release timing
`timescale 1ns/10ps
module hrps_chk
  import hrps_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // requests and modes
  input wire logic        reset_n_pin,
  input wire logic        soft_reset,
  input wire logic        main_clk_stable,
  input wire logic        processor_mode_pin,
  input wire logic        bus_grant_req,
  // observed outputs
  input wire logic        core_in_reset,
  input wire logic        fetch_valid,
  input wire logic [19:0] fetch_addr,
  input hrps_bus_ctl_t    bus_ctl,
  input wire logic        bus_ctl_oe,
  input wire logic        addr_oe,
  input wire logic [2:0]  pulled_up_port_pins,
  input wire logic [2:0]  pulled_up_port_pins_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire req = !reset_n_pin || soft_reset;
  wire bm  = core_in_reset && processor_mode_pin;
  enter_rst_a: assert property (req |=> core_in_reset)
    else $error("reset not entered");
  release_a: assert property (core_in_reset && !req && main_clk_stable
    |=> !core_in_reset ##1 (fetch_valid && fetch_addr == RESET_VECTOR_ADDR))
    else $error("bad release");
  hold_rst_a: assert property (core_in_reset && !main_clk_stable
    |=> core_in_reset) else $error("left reset on unstable clock");
  cs_high_a: assert property (bm |-> bus_ctl.chip_select_zero)
    else $error("chip select low");
  wr_high_a: assert property (bm |-> bus_ctl.wr_strobe)
    else $error("store strobe low");
  rd_high_a: assert property (bm |-> bus_ctl.rd_strobe)
    else $error("read strobe low");
  latch_low_a: assert property (bm |-> !bus_ctl.addr_latch)
    else $error("latch high");
  ack_follow_a: assert property (bm && $past(core_in_reset) && !$past(rst)
    |-> bus_ctl.bus_release_ack == $past(bus_grant_req))
    else $error("ack not following grant");
  port_float_a: assert property (core_in_reset && !processor_mode_pin
    |-> !bus_ctl_oe && !addr_oe && pulled_up_port_pins_oe == 3'h0)
    else $error("pin driven in single-chip reset");
  pull_up_a: assert property (core_in_reset |-> pulled_up_port_pins == 3'h7)
    else $error("pull-ups off");
  cover property (bm);
  cover property (soft_reset ##1 core_in_reset);
  cover property (fetch_valid);
endmodule : hrps_chk

// ===== testbench/hrps_supervisor.sv
// reset supervisor model: holds the reset pin low after a start pulse
`timescale 1ns/10ps
module hrps_supervisor #(
  parameter int HOLD = 20
) (
  // clock and control
  input  wire logic core_clk,
  input  wire logic go,
  input  wire logic main_clk_stable,
  // reset pin
  output logic      reset_n_pin
);
  int cnt = 0;
  // parks at one while the clock is unstable, so release waits for it
  always @(posedge core_clk) begin
    if (go) cnt <= HOLD;
    else if (cnt > 1 || (cnt == 1 && main_clk_stable)) cnt <= cnt - 1;
  end
  assign reset_n_pin = (cnt == 0);
endmodule : hrps_supervisor

// ===== testbench/tb_top.sv
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
module tb_top;
  import hrps_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, go = 1'b0, soft_reset = 1'b0;
  logic main_clk_stable = 1'b1, processor_mode_pin = 1'b0;
  logic bus_grant_req = 1'b0, reset_n_pin, core_in_reset, fetch_valid;
  logic bus_ctl_oe, bus_clk_out, bus_clk_oe, addr_oe;
  hrps_ram_wr_t  ram_wr = '0;
  hrps_bus_ctl_t bus_ctl;
  logic [13:0]   ram_rd_addr = 14'h0000;
  logic [19:0]   fetch_addr, addr_out;
  logic [7:0]    ram_rd_data, data_lo_oe, data_hi_oe;
  logic [2:0]    pulled_up_port_pins, pulled_up_port_pins_oe;
  int            errors = 0;
  int            n_checks = 0;
  logic          clk_prev;
  // inputs, then expected cs, store, read, latch, ack and enables
  typedef struct packed {
    logic       mode;
    logic       sw;
    logic       grant;
    logic [4:0] exp_ctl;
    logic [2:0] exp_oe;
  } hrps_row_t;
  hrps_row_t rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 5'h00, 3'h0}, '{1'b0, 1'b1, 1'b0, 5'h00, 3'h0},
    '{1'b1, 1'b0, 1'b0, 5'h1C, 3'h7}, '{1'b1, 1'b0, 1'b1, 5'h1D, 3'h7},
    '{1'b1, 1'b1, 1'b0, 5'h1C, 3'h7}, '{1'b1, 1'b1, 1'b1, 5'h1D, 3'h7}};
  always #2.5 core_clk = ~core_clk;
  hrps_supervisor u_hrps_supervisor (.core_clk, .go, .main_clk_stable,
    .reset_n_pin);
  hrps_core u_hrps_core (.core_clk, .rst, .reset_n_pin, .soft_reset,
    .main_clk_stable, .processor_mode_pin, .bus_16bit(1'b0),
    .bus_grant_req, .ram_wr, .ram_rd_addr, .cpu_addr(20'h00000),
    .cpu_bus_ctl('1), .core_in_reset, .fetch_valid, .fetch_addr,
    .ram_rd_data, .bus_ctl, .bus_ctl_oe, .bus_clk_out, .bus_clk_oe,
    .addr_out, .addr_oe, .data_lo_oe, .data_hi_oe, .pulled_up_port_pins,
    .pulled_up_port_pins_oe);
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wait_fetch();
    for (int i = 0; i < 100 && fetch_valid !== 1'b1; i++) cyc(1);
    if (fetch_valid !== 1'b1) begin
      $display("[ERR] %0t fetch timeout", $time);
      errors++;
      tally_and_finish();
    end else begin
      chk(fetch_addr === RESET_VECTOR_ADDR && core_in_reset === 1'b0,
          "fetch");
    end
  endtask : wait_fetch
  // write, optionally hit by a reset in the same cycle, then read back
  task automatic ram_io(input logic [7:0] wd, input logic sw,
                        input logic [7:0] exp);
    ram_wr = '{1'b1, 14'h0123, wd};
    soft_reset = sw;
    cyc(1);
    ram_wr.we = 1'b0;
    if (sw) begin
      cyc(20);
      soft_reset = 1'b0;
      wait_fetch();
    end
    ram_rd_addr = 14'h0123;
    cyc(2);
    chk(ram_rd_data === exp, "ram data");
  endtask : ram_io
  initial begin
    cyc(2);
    rst = 1'b0;
    wait_fetch();
    $display("test reset done");
    foreach (rows[k]) begin
      processor_mode_pin = rows[k].mode;
      bus_grant_req = rows[k].grant;
      if (rows[k].sw) soft_reset = 1'b1;
      else go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(4);
      if (rows[k].mode) begin
        chk(bus_ctl[5:1] === rows[k].exp_ctl,
            "bus pins");
        chk({bus_ctl_oe, addr_oe, bus_clk_oe} === rows[k].exp_oe,
            "bus oe");
        chk({pulled_up_port_pins, pulled_up_port_pins_oe} === 6'h38,
            "pull");
        clk_prev = bus_clk_out;
        cyc(1);
        chk(bus_clk_out !== clk_prev && addr_out === 20'h00000,
            "bus clock");
      end else begin
        chk({bus_ctl_oe, addr_oe, bus_clk_oe, data_lo_oe, data_hi_oe,
             pulled_up_port_pins_oe} === {rows[k].exp_oe, 19'h00000},
            "float");
      end
      cyc(16);
      soft_reset = 1'b0;
      wait_fetch();
      $display("test row %0d done", k);
    end
    main_clk_stable = 1'b0;
    soft_reset = 1'b1;
    cyc(20);
    soft_reset = 1'b0;
    cyc(10);
    chk(core_in_reset === 1'b1, "left reset early");
    main_clk_stable = 1'b1;
    wait_fetch();
    $display("test unstable done");
    ram_io(8'h5A, 1'b0, 8'h5A);
    ram_io(8'hC3, 1'b1, 8'h5A);
    $display("test ram done");
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk(core_in_reset === 1'b1 && bus_ctl[5:2] === 4'hE, "sync reset");
    wait_fetch();
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : tb_top
bind hrps_core hrps_chk u_hrps_chk (.core_clk, .rst, .reset_n_pin,
  .soft_reset, .main_clk_stable, .processor_mode_pin, .bus_grant_req,
  .core_in_reset, .fetch_valid, .fetch_addr, .bus_ctl, .bus_ctl_oe,
  .addr_oe, .pulled_up_port_pins, .pulled_up_port_pins_oe);
